// ### tlv_pkg.sv
// Purpose: Shared constants and types of the two-level vectored interrupt controller.
// Assumes: APB data is 32 bits wide and every register takes one aligned word.
// Notes:   Pending flags are indexed by fixed order number, 0 wins within one level.
package tlv_pkg;

  // ----------------------------------------------------------------
  // Sources and vectors
  // ----------------------------------------------------------------
  localparam int          NUM_SRC     = 22;
  localparam int          IDX_W       = 5;
  localparam logic [15:0] VEC_BASE    = 16'h0003;
  localparam int          VEC_SHIFT   = 3;
  localparam int          EXT_A_ORDER = 0;
  localparam int          EXT_B_ORDER = 2;
  // Sources whose pending flag the hardware clears when the core vectors.
  localparam logic [21:0] HW_CLR_MASK = 22'h08000A;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int CALL_CLOCKS  = 4;
  localparam int DETECT_CLOCKS = 1;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TIMER_EXT_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] IRQ_ENABLE_REG_OFS        = 8'h04;
  localparam logic [7:0] IRQ_LEVEL_REG_OFS         = 8'h08;
  localparam logic [7:0] IRQ_PENDING_REG_OFS       = 8'h0C;
  localparam logic [7:0] IRQ_STATUS_REG_OFS        = 8'h10;

  localparam int EXT_A_TRIGGER_BIT = 0;
  localparam int EXT_A_PENDING_BIT = 1;
  localparam int EXT_B_TRIGGER_BIT = 2;
  localparam int EXT_B_PENDING_BIT = 3;
  localparam int GLOBAL_EN_BIT     = 31;

  localparam logic [21:0] ENABLE_RESET = 22'h000000;
  localparam logic [21:0] LEVEL_RESET  = 22'h000000;
  localparam logic [21:0] PEND_RESET   = 22'h000000;

  typedef enum logic {TLV_IDLE, TLV_CALL} tlv_state_t;

endpackage

// ### tlv_ext_input.sv
// Purpose: Conditions one active-low external interrupt pin into a pending flag.
// Assumes: Pin is asynchronous to clk.
// Notes:   Level mode mirrors the pin; edge mode latches a falling edge.
`timescale 1ns/100ps
module tlv_ext_input
  import tlv_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic extIrqN,
  input  wire logic triggerType,
  input  wire logic swSet,
  input  wire logic swClr,
  input  wire logic vecClr,
  output logic      pending
);

  logic syncA_q;
  logic syncB_q;
  logic prev_q;
  logic pend_q;
  logic pend_d;

  // ----------------------------------------------------------------
  // Pending flag
  // ----------------------------------------------------------------
  always_comb
  begin
    pend_d = pend_q;
    if (!triggerType)
    begin
      pend_d = ~syncB_q;
    end
    else
    begin
      if (swClr || vecClr)
      begin
        pend_d = 1'b0;
      end
      if ((prev_q && !syncB_q) || swSet)
      begin
        pend_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      syncA_q <= 1'b1;
      syncB_q <= 1'b1;
      prev_q  <= 1'b1;
      pend_q  <= 1'b0;
    end
    else
    begin
      syncA_q <= extIrqN;
      syncB_q <= syncA_q;
      prev_q  <= syncB_q;
      pend_q  <= pend_d;
    end
  end

  assign pending = pend_q;

endmodule

// ### tlv_irq_ctrl.sv
// Purpose: Two-level vectored interrupt controller with APB register access.
// Assumes: Peripheral events arrive as one-cycle pulses synchronous to clk.
// Notes:   The core reports instruction and return ends; this block issues the call.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
// Functional notes
// - External inputs active low, level or falling edge.
// - External pending flags at control bits 1, 3.
// - Edge-mode flag cleared when core vectors.
// - Level-mode flag mirrors pin, not cleared.
// - Vector is 0x0003 plus eight times order.
// - Each source has one priority level bit.
// - Priority bits reset to low level.
// - High request preempts running low routine.
// - Nothing preempts a running high routine.
// - High level request wins over low.
// - Equal level: smallest order number wins.
// - Flags sampled and decoded every clock.
// - Fastest response: detect 1 plus call 4.
// - After return, one instruction before call.
// - Worst response 18 clocks, from core timing.
// - Equal or lower request waits return plus one.
// - Global enable zero masks every source.
// - Flags set regardless of enable; persist retrigger, except on-chip sources 1, 3, 19.
// - Software write of one acts as event, except on an external input in level mode.
module tlv_irq_ctrl
  import tlv_pkg::*;
#(
  parameter int NSRC = NUM_SRC
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_a_n,
  input  wire logic        ext_irq_b_n,
  input  wire logic [21:0] periphEvent,
  input  wire logic        instrEnd,
  input  wire logic        retiEnd,
  output logic             callStart,
  output logic      [15:0] callVector,
  output logic             isrEnter,
  output logic             activeLow,
  output logic             activeHigh
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [21:0]      enable_q;
  logic [21:0]      enable_d;
  logic             globalEn_q;
  logic             globalEn_d;
  logic [21:0]      level_q;
  logic [21:0]      level_d;
  logic [21:0]      pend_q;
  logic [21:0]      pend_d;
  logic             extATrig_q;
  logic             extATrig_d;
  logic             extBTrig_q;
  logic             extBTrig_d;
  logic [31:0]      prdata_q;
  logic [31:0]      prdata_d;
  logic             pready_q;
  logic             pready_d;
  logic             pslverr_q;
  logic             pslverr_d;
  logic             winValid_q;
  logic             winValid_d;
  logic             winHigh_q;
  logic             winHigh_d;
  logic [IDX_W-1:0] winIdx_q;
  logic [IDX_W-1:0] winIdx_d;
  tlv_state_t       state_q;
  tlv_state_t       state_d;
  logic [2:0]       callCnt_q;
  logic [2:0]       callCnt_d;
  logic             actLow_q;
  logic             actLow_d;
  logic             actHigh_q;
  logic             actHigh_d;
  logic             holdOff_q;
  logic             holdOff_d;
  logic             callStart_q;
  logic             callStart_d;
  logic [15:0]      callVec_q;
  logic [15:0]      callVec_d;
  logic             isrEnter_q;
  logic             isrEnter_d;
  logic [21:0]      vecClr;
  logic [21:0]      flags;
  logic [21:0]      reqMask;
  logic             access;
  logic             wrAccess;
  logic             wrExtCtl;
  logic             wrPend;
  logic             extAPend;
  logic             extBPend;
  logic             take;

  localparam logic [2:0] CALL_LAST = 3'(CALL_CLOCKS - 1);

  assign access   = psel && penable && pready_q;
  assign wrAccess = access && pwrite && !pslverr_q;
  assign wrExtCtl = wrAccess && (paddr[7:0] == TIMER_EXT_CONTROL_REG_OFS);
  assign wrPend   = wrAccess && (paddr[7:0] == IRQ_PENDING_REG_OFS);

  // ----------------------------------------------------------------
  // External inputs
  // ----------------------------------------------------------------
  tlv_ext_input u_ext_a (
    .clk         (clk),
    .reset_n     (reset_n),
    .extIrqN     (ext_irq_a_n),
    .triggerType (extATrig_q),
    .swSet       ((wrExtCtl && pwdata[EXT_A_PENDING_BIT])
                  || (wrPend && pwdata[EXT_A_ORDER])),
    .swClr       ((wrExtCtl && !pwdata[EXT_A_PENDING_BIT])
                  || (wrPend && !pwdata[EXT_A_ORDER])),
    .vecClr      (vecClr[EXT_A_ORDER]),
    .pending     (extAPend)
  );

  tlv_ext_input u_ext_b (
    .clk         (clk),
    .reset_n     (reset_n),
    .extIrqN     (ext_irq_b_n),
    .triggerType (extBTrig_q),
    .swSet       ((wrExtCtl && pwdata[EXT_B_PENDING_BIT])
                  || (wrPend && pwdata[EXT_B_ORDER])),
    .swClr       ((wrExtCtl && !pwdata[EXT_B_PENDING_BIT])
                  || (wrPend && !pwdata[EXT_B_ORDER])),
    .vecClr      (vecClr[EXT_B_ORDER]),
    .pending     (extBPend)
  );

  // ----------------------------------------------------------------
  // Pending flags of on-chip sources
  // ----------------------------------------------------------------
  always_comb
  begin
    pend_d = pend_q & ~(vecClr & HW_CLR_MASK);
    if (wrPend)
    begin
      pend_d = pwdata[21:0];
    end
    pend_d = pend_d | periphEvent;
  end

  always_comb
  begin
    flags              = pend_q;
    flags[EXT_A_ORDER] = extAPend;
    flags[EXT_B_ORDER] = extBPend;
  end

  assign reqMask = globalEn_q ? (flags & enable_q) : '0;

  // ----------------------------------------------------------------
  // Priority decode
  // ----------------------------------------------------------------
  always_comb
  begin
    winValid_d = 1'b0;
    winHigh_d  = 1'b0;
    winIdx_d   = '0;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (reqMask[i] && !level_q[i])
      begin
        winValid_d = 1'b1;
        winIdx_d   = IDX_W'(i);
      end
    end
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (reqMask[i] && level_q[i])
      begin
        winValid_d = 1'b1;
        winHigh_d  = 1'b1;
        winIdx_d   = IDX_W'(i);
      end
    end
  end

  // ----------------------------------------------------------------
  // Call sequencer
  // ----------------------------------------------------------------
  assign take = (state_q == TLV_IDLE) && winValid_q && reqMask[winIdx_q]
                && instrEnd && !holdOff_q
                && !actHigh_q
                && (winHigh_q || !actLow_q);

  assign vecClr = take ? (22'h000001 << winIdx_q) : 22'h000000;

  always_comb
  begin
    state_d     = state_q;
    callCnt_d   = callCnt_q;
    actLow_d    = actLow_q;
    actHigh_d   = actHigh_q;
    holdOff_d   = holdOff_q && !instrEnd;
    callStart_d = 1'b0;
    isrEnter_d  = 1'b0;
    callVec_d   = callVec_q;
    if (retiEnd)
    begin
      holdOff_d = 1'b1;
      actLow_d  = actLow_q && actHigh_q;
      actHigh_d = 1'b0;
    end
    unique case (state_q)
      TLV_IDLE:
      begin
        if (take)
        begin
          state_d     = TLV_CALL;
          callCnt_d   = CALL_LAST;
          callStart_d = 1'b1;
          callVec_d   = VEC_BASE + {8'h00, winIdx_q, 3'h0};
          actHigh_d   = actHigh_q || winHigh_q;
          actLow_d    = actLow_q || !winHigh_q;
        end
      end
      TLV_CALL:
      begin
        if (callCnt_q == 3'h1)
        begin
          isrEnter_d = 1'b1;
          state_d    = TLV_IDLE;
        end
        callCnt_d = callCnt_q - 3'h1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  always_comb
  begin
    enable_d   = enable_q;
    globalEn_d = globalEn_q;
    level_d    = level_q;
    extATrig_d = extATrig_q;
    extBTrig_d = extBTrig_q;
    pready_d   = psel && !penable;
    prdata_d   = 32'h00000000;
    pslverr_d  = 1'b0;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr[7:0])
        TIMER_EXT_CONTROL_REG_OFS:
        begin
          prdata_d[EXT_A_TRIGGER_BIT] = extATrig_q;
          prdata_d[EXT_A_PENDING_BIT] = extAPend;
          prdata_d[EXT_B_TRIGGER_BIT] = extBTrig_q;
          prdata_d[EXT_B_PENDING_BIT] = extBPend;
        end
        IRQ_ENABLE_REG_OFS:
        begin
          prdata_d[21:0]          = enable_q;
          prdata_d[GLOBAL_EN_BIT] = globalEn_q;
        end
        IRQ_LEVEL_REG_OFS:   prdata_d[21:0] = level_q;
        IRQ_PENDING_REG_OFS: prdata_d[21:0] = flags;
        IRQ_STATUS_REG_OFS:
        begin
          prdata_d[15:0] = callVec_q;
          prdata_d[16]   = actLow_q;
          prdata_d[17]   = actHigh_q;
          prdata_d[18]   = holdOff_q;
        end
        default: pslverr_d = 1'b1;
      endcase
    end
    pslverr_d = pslverr_d || (psel && !penable && (paddr[1:0] != 2'h0
                || paddr[31:8] != 24'h000000 || paddr[7:0] > IRQ_STATUS_REG_OFS));
    if (wrExtCtl)
    begin
      extATrig_d = pwdata[EXT_A_TRIGGER_BIT];
      extBTrig_d = pwdata[EXT_B_TRIGGER_BIT];
    end
    if (wrAccess && paddr[7:0] == IRQ_ENABLE_REG_OFS)
    begin
      enable_d   = pwdata[21:0];
      globalEn_d = pwdata[GLOBAL_EN_BIT];
    end
    if (wrAccess && paddr[7:0] == IRQ_LEVEL_REG_OFS)
    begin
      level_d = pwdata[21:0];
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      enable_q    <= ENABLE_RESET;
      globalEn_q  <= 1'b0;
      level_q     <= LEVEL_RESET;
      pend_q      <= PEND_RESET;
      extATrig_q  <= 1'b0;
      extBTrig_q  <= 1'b0;
      prdata_q    <= 32'h00000000;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
      winValid_q  <= 1'b0;
      winHigh_q   <= 1'b0;
      winIdx_q    <= '0;
      state_q     <= TLV_IDLE;
      callCnt_q   <= 3'h0;
      actLow_q    <= 1'b0;
      actHigh_q   <= 1'b0;
      holdOff_q   <= 1'b0;
      callStart_q <= 1'b0;
      callVec_q   <= 16'h0000;
      isrEnter_q  <= 1'b0;
    end
    else
    begin
      enable_q    <= enable_d;
      globalEn_q  <= globalEn_d;
      level_q     <= level_d;
      pend_q      <= pend_d;
      extATrig_q  <= extATrig_d;
      extBTrig_q  <= extBTrig_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
      winValid_q  <= winValid_d;
      winHigh_q   <= winHigh_d;
      winIdx_q    <= winIdx_d;
      state_q     <= state_d;
      callCnt_q   <= callCnt_d;
      actLow_q    <= actLow_d;
      actHigh_q   <= actHigh_d;
      holdOff_q   <= holdOff_d;
      callStart_q <= callStart_d;
      callVec_q   <= callVec_d;
      isrEnter_q  <= isrEnter_d;
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign callStart  = callStart_q;
  assign callVector = callVec_q;
  assign isrEnter   = isrEnter_q;
  assign activeLow  = actLow_q;
  assign activeHigh = actHigh_q;

endmodule

// ### tlv_irq_ctrl_props.sv
// Purpose: Checker for the call timing on the core side of the controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Bound to every instance of tlv_irq_ctrl.
`timescale 1ns/100ps
module tlv_irq_ctrl_props
  import tlv_pkg::*;
#(
  parameter int NSRC = NUM_SRC
)
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        instrEnd,
  input wire logic        retiEnd,
  input wire logic        callStart,
  input wire logic [15:0] callVector,
  input wire logic        isrEnter,
  input wire logic        activeLow,
  input wire logic        activeHigh
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_call_gap;
    callStart |=> !callStart [*3];
  endproperty
  a_call_gap: assert property (p_call_gap) else $error("Call inside long call.");

  property p_isr_enter;
    callStart |-> ##3 isrEnter;
  endproperty
  a_isr_enter: assert property (p_isr_enter) else $error("Routine entry late.");

  property p_vec_form;
    callStart |-> (callVector[2:0] == 3'h3) && (callVector <= 16'h00AB);
  endproperty
  a_vec_form: assert property (p_vec_form) else $error("Vector malformed.");

  property p_vec_hold;
    $changed(callVector) |-> callStart;
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("Vector moved alone.");

  property p_call_cause;
    callStart |-> $past(instrEnd);
  endproperty
  a_call_cause: assert property (p_call_cause) else $error("Call without end.");

  property p_return_from_irq_instr_hold;
    retiEnd |=> !callStart;
  endproperty
  a_return_from_irq_instr_hold: assert property (p_return_from_irq_instr_hold) else $error("Call right after return.");

  property p_high_hold;
    activeHigh && $past(activeHigh) |-> !callStart;
  endproperty
  a_high_hold: assert property (p_high_hold) else $error("High routine preempted.");

  property p_low_preempt;
    callStart && $past(activeLow) |-> activeHigh;
  endproperty
  a_low_preempt: assert property (p_low_preempt) else $error("Low nested in low.");
endmodule

bind tlv_irq_ctrl tlv_irq_ctrl_props #(.NSRC(NSRC)) u_tlv_irq_ctrl_props (
  .clk(clk), .reset_n(reset_n), .instrEnd(instrEnd), .retiEnd(retiEnd),
  .callStart(callStart), .callVector(callVector), .isrEnter(isrEnter),
  .activeLow(activeLow), .activeHigh(activeHigh));

// ### tlv_core_model.sv
// Purpose: Core sequencer model reporting instruction and return ends.
// Assumes: Return requested by the bench as a one-cycle pulse.
// Notes:   Slow mode ends one instruction every fourth cycle.
`timescale 1ns/100ps
module tlv_core_model
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic slow,
  input  wire logic retiReq,
  output logic      instrEnd,
  output logic      retiEnd
);
  logic [1:0] cnt_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q   <= 2'h0;
      retiEnd <= 1'b0;
    end
    else
    begin
      cnt_q   <= cnt_q + 2'h1;
      retiEnd <= retiReq;
    end
  end

  // The instruction after a return always completes before a new call.
  assign instrEnd = reset_n && !retiEnd && (!slow || (cnt_q == 2'h3));
endmodule

// ### tlv_irq_ctrl_bench.sv
// Purpose: Self-checking bench of the interrupt controller.
// Assumes: Core model answers promptly or slowly.
// Notes:   Registers are reached over APB.
`timescale 1ns/100ps
module tlv_irq_ctrl_bench;
  import tlv_pkg::*;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, slvErr;
  logic        irqAN, irqBN, slow, retiReq, instrEnd, retiEnd, callStart;
  logic        isrEnter, activeLow, activeHigh;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [21:0] periphEvent;
  logic [15:0] callVector;
  int          errCount, nTests;

  tlv_irq_ctrl u_tlv_irq_ctrl (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_irq_a_n(irqAN), .ext_irq_b_n(irqBN),
    .periphEvent(periphEvent), .instrEnd(instrEnd), .retiEnd(retiEnd),
    .callStart(callStart), .callVector(callVector), .isrEnter(isrEnter),
    .activeLow(activeLow), .activeHigh(activeHigh));
  tlv_core_model u_tlv_core_model (.clk(clk), .reset_n(reset_n), .slow(slow),
    .retiReq(retiReq), .instrEnd(instrEnd), .retiEnd(retiEnd));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {24'h000000, a};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd      = prdata;
    slvErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic ev(input logic [21:0] m);
    periphEvent <= m;
    @(posedge clk);
    periphEvent <= 22'h000000;
  endtask

  task automatic waitCall(input logic [15:0] v);
    int i;
    i = 0;
    @(posedge clk);
    while (callStart !== 1'b1 && i < 60)
    begin
      @(posedge clk);
      i++;
    end
    chk("callVector", {16'h0000, v}, (callStart === 1'b1) ? {16'h0000, callVector} : '1);
  endtask

  task automatic noCall(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge clk);
      seen |= (callStart === 1'b1);
    end
    chk("noCall", 32'h00000000, {31'h00000000, seen});
  endtask

  task automatic done();
    apb(1'b1, IRQ_PENDING_REG_OFS, 32'h00000000);
    retiReq <= 1'b1;
    @(posedge clk);
    retiReq <= 1'b0;
    @(posedge clk);
  endtask

  task automatic endSim();
    $display("Checks %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tReset();
    apb(1'b0, IRQ_LEVEL_REG_OFS, 32'h00000000);
    chk("level", 32'h00000000, rd);
    apb(1'b0, 8'h40, 32'h00000000);
    chk("pslverr", 32'h00000001, {31'h00000000, slvErr});
    $display("Test reset done");
  endtask

  task automatic tMask();
    apb(1'b1, IRQ_ENABLE_REG_OFS, 32'h00000020);
    ev(22'h000020);
    noCall(20);
    apb(1'b0, IRQ_PENDING_REG_OFS, 32'h00000000);
    chk("pend5", 32'h00000020, rd & 32'h00000020);
    apb(1'b1, IRQ_ENABLE_REG_OFS, 32'h80000020);
    waitCall(16'h002B);
    done();
    $display("Test mask done");
  endtask

  task automatic tOrder();
    apb(1'b1, IRQ_ENABLE_REG_OFS, 32'h803FFFFF);
    ev(22'h000220);
    waitCall(16'h002B);
    done();
    apb(1'b1, IRQ_LEVEL_REG_OFS, 32'h00000210);
    apb(1'b0, IRQ_LEVEL_REG_OFS, 32'h00000000);
    chk("levelRb", 32'h00000210, rd);
    ev(22'h000220);
    waitCall(16'h004B);
    done();
    $display("Test order done");
  endtask

  task automatic tPreempt();
    ev(22'h000020);
    waitCall(16'h002B);
    ev(22'h000040);
    noCall(15);
    ev(22'h000200);
    waitCall(16'h004B);
    chk("activeHigh", 32'h00000001, {31'h00000000, activeHigh});
    ev(22'h000010);
    noCall(15);
    done();
    done();
    $display("Test preempt done");
  endtask

  task automatic tRetrig();
    ev(22'h000080);
    waitCall(16'h003B);
    chk("activeLow", 32'h00000001, {31'h00000000, activeLow});
    repeat (3) @(posedge clk);
    chk("isrEnter", 32'h00000001, {31'h00000000, isrEnter});
    retiReq <= 1'b1;
    @(posedge clk);
    retiReq <= 1'b0;
    waitCall(16'h003B);
    done();
    $display("Test retrigger done");
  endtask

  task automatic tSoftSet();
    slow <= 1'b1;
    for (int k = 1; k < 22; k++)
    begin
      if (k != 2)
      begin
        apb(1'b1, IRQ_PENDING_REG_OFS, 32'h00000001 << k);
        waitCall(16'h0003 + 16'(k * 8));
        done();
      end
    end
    slow <= 1'b0;
    $display("Test software set done");
  endtask

  task automatic tExt();
    apb(1'b1, IRQ_ENABLE_REG_OFS, 32'h003FFFFF);
    apb(1'b1, TIMER_EXT_CONTROL_REG_OFS, 32'h00000001);
    irqAN <= 1'b0;
    repeat (6) @(posedge clk);
    apb(1'b0, TIMER_EXT_CONTROL_REG_OFS, 32'h00000000);
    chk("pendA", 32'h00000002, rd & 32'h00000002);
    apb(1'b1, IRQ_ENABLE_REG_OFS, 32'h803FFFFF);
    waitCall(16'h0003);
    apb(1'b0, TIMER_EXT_CONTROL_REG_OFS, 32'h00000000);
    chk("pendAClr", 32'h00000000, rd & 32'h00000002);
    irqAN <= 1'b1;
    done();
    apb(1'b1, TIMER_EXT_CONTROL_REG_OFS, 32'h00000000);
    irqBN <= 1'b0;
    waitCall(16'h0013);
    apb(1'b0, TIMER_EXT_CONTROL_REG_OFS, 32'h00000000);
    chk("pendB", 32'h00000008, rd & 32'h00000008);
    irqBN <= 1'b1;
    repeat (5) @(posedge clk);
    apb(1'b0, TIMER_EXT_CONTROL_REG_OFS, 32'h00000000);
    chk("pendBLow", 32'h00000000, rd & 32'h00000008);
    done();
    $display("Test external done");
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    reset_n     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h00000000;
    pwdata      = 32'h00000000;
    irqAN       = 1'b1;
    irqBN       = 1'b1;
    slow        = 1'b0;
    retiReq     = 1'b0;
    periphEvent = 22'h000000;
    errCount    = 0;
    nTests      = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    tReset();
    tMask();
    tOrder();
    tPreempt();
    tRetrig();
    tSoftSet();
    tExt();
    endSim();
  end

  initial
  begin
    repeat (30000) @(posedge clk);
    errCount++;
    endSim();
  end
endmodule
